// >>> core/hmcg_halt.sv
`timescale 1ns/1ps
// What this block does
// - Halt is entered only when the processor executes the halt instruction.
// - Halt entry is allowed from any processor clock source.
// - Halt gates off the processor clock and stops flash operation.
// - The main oscillator feeding the processor keeps running and cannot be stopped.
// - Other oscillators keep the run or stop state they had at entry.
// - External clocks not feeding the processor follow their input pins.
// - RAM and port output latches hold their contents throughout halt.
// - Watchdog runs in halt unless low-speed oscillator stop is allowed.
module hmcg_halt #(
	parameter int OSC_N = hmcg_pkg::OSC_COUNT, // Oscillator run-vector width
	parameter int SRC_N = hmcg_pkg::SRC_COUNT  // Number of CPU clock sources
) (
	input  wire logic                         sys_clk,        // System clock, 40 MHz
	input  wire logic                         rst,            // Synchronous reset, high
	input  wire logic                         halt_exec,      // Halt instruction executed
	input  wire logic                         wake,           // Halt release request
	input  wire logic [2:0]                   cpu_src,        // CPU clock source code
	input  wire logic [OSC_N-1:0]             osc_req,        // Software oscillator enables
	input  wire logic                         ext_main_in,    // External main clock present
	input  wire logic                         ext_sub_in,     // External subsystem present
	input  wire logic                         opt_low_stop,   // Option: low-speed may stop
	output logic                              halted,         // Halt state indicator
	output logic                              cpu_clk_en,     // CPU clock gate enable
	output logic                              flash_en,       // Flash operation enable
	output logic [OSC_N-1:0]                  osc_run,        // Oscillator run enables
	output logic                              ext_main_en,    // External main clock pass
	output logic                              ext_sub_en,     // External sub clock pass
	output logic                              mem_wr_en,      // RAM and port latch write enable
	output logic                              wdt_clk_en,     // Watchdog clock enable
	output logic                              periph_clk_en   // Peripheral clock enable
);
	import hmcg_pkg::*;

	// Held state, snapshots and decoded views of the live inputs
	hmcg_state_type       state;
	hmcg_state_type       next_state;
	logic [OSC_N-1:0]     osc_hold;
	logic [OSC_N-1:0]     osc_bit;
	logic [OSC_N-1:0]     src_mask;
	logic [OSC_N-1:0]     osc_live;
	logic [2:0]           entry_src;
	logic [2:0]           live_src;
	logic                 halt_next;
	logic                 halt_stay;
	logic                 main_feeds;
	logic                 sub_feeds;

	// The decoders below know exactly four oscillators and five sources
	if (OSC_N != OSC_COUNT) begin : g_bad_osc
		$error("hmcg_halt: unsupported oscillator count");
	end
	if (SRC_N != SRC_COUNT) begin : g_bad_src
		$error("hmcg_halt: unsupported source count");
	end

	// Oscillator driving the CPU for a given source code
	function automatic logic [OSC_N-1:0] src_osc(input logic [2:0] src);
		logic [OSC_N-1:0] v;
		v = '0;
		case (src)
			SRC_INT_HS:  v[OSC_INT_HS] = 1'b1;
			SRC_CRYSTAL: v[OSC_CRYSTAL] = 1'b1;
			SRC_XT_SUB:  v[OSC_XT_SUB] = 1'b1;
			default:     v = '0;
		endcase
		return v;
	endfunction

	// True when the given code names the source that clocks the CPU
	function automatic logic feeds_cpu(input logic [2:0] src, input logic [2:0] code);
		return (src == code);
	endfunction

	// While halted the CPU cannot rewrite its selector, so the entry source rules
	assign live_src   = (state == HMCG_HALT) ? entry_src : cpu_src;
	assign src_mask   = src_osc(live_src);
	assign osc_live   = osc_req | src_mask;

	// Decodes shared by the gate and oscillator flops
	assign halt_next  = (next_state == HMCG_HALT);
	assign halt_stay  = halt_next && (state == HMCG_HALT);
	assign main_feeds = feeds_cpu(live_src, SRC_EXT_MAIN);
	assign sub_feeds  = feeds_cpu(live_src, SRC_EXT_SUB);

	always_comb begin
		next_state = state;
		case (state)
			HMCG_RUN: begin
				if (halt_exec) begin
					next_state = HMCG_HALT;
				end
			end
			HMCG_HALT: begin
				if (wake) begin
					next_state = HMCG_RUN;
				end
			end
			default: next_state = HMCG_RUN;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= HMCG_RUN;
		end else begin
			state <= next_state;
		end
	end

	// Snapshot oscillator enables at entry so software cannot change them in halt
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			osc_hold <= OSC_RESET;
		end else if (state == HMCG_RUN) begin
			osc_hold <= osc_req | src_osc(cpu_src);
		end
	end

	// Source in use at entry; a stopped CPU cannot change it, so hold it here
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			entry_src <= SRC_INT_HS;
		end else if (state == HMCG_RUN) begin
			entry_src <= cpu_src;
		end
	end

	// Gates are registered so the CPU sees a glitch-free enable
	// The halt flag mirrors the state register one for one
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			halted <= 1'b0;
		end else begin
			halted <= halt_next;
		end
	end

	// The enable drops on the entry edge itself, so no instruction follows halt
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cpu_clk_en <= 1'b1;
		end else begin
			cpu_clk_en <= !halt_next;
		end
	end

	// Flash stops together with the CPU; nothing else fetches from it
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flash_en <= 1'b1;
		end else begin
			flash_en <= !halt_next;
		end
	end

	// Writes are withheld rather than clocks, so RAM and latches keep their values
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mem_wr_en <= 1'b1;
		end else begin
			mem_wr_en <= !halt_next;
		end
	end

	// One flop per oscillator; the source bit is ORed in so software cannot stop it
	// A flop per bit costs nothing extra and keeps each enable independent
	for (genvar g = 0; g < OSC_N; g++) begin : g_osc
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				osc_bit[g] <= OSC_RESET[g];
			end else if (halt_stay) begin
				osc_bit[g] <= osc_hold[g] | src_mask[g];
			end else begin
				// Running and the entry edge both follow the live request
				osc_bit[g] <= osc_live[g];
			end
		end
	end
	assign osc_run = osc_bit;

	// An external clock is only passed on; it runs or stops with its pin
	// The one feeding the CPU is forced through so halt cannot cut it
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ext_main_en <= 1'b0;
		end else begin
			ext_main_en <= ext_main_in | main_feeds;
		end
	end

	// Same treatment for the subsystem pin
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ext_sub_en <= 1'b0;
		end else begin
			ext_sub_en <= ext_sub_in | sub_feeds;
		end
	end

	// Limitation: the option input is sampled live, so it must stay static
	// The option comes from a configuration byte, which never changes at run time
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wdt_clk_en <= 1'b1;
		end else begin
			wdt_clk_en <= !(halt_next && opt_low_stop);
		end
	end

	// Peripheral clocks are never gated here; their own enables stay in charge
	// so timers, serial ports and the converter run straight through halt
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			periph_clk_en <= 1'b1;
		end else begin
			periph_clk_en <= 1'b1;
		end
	end
endmodule

// >>> core/hmcg_pkg.sv
package hmcg_pkg;
	// CPU clock source selector codes
	localparam logic [2:0] SRC_INT_HS   = 3'h0;
	localparam logic [2:0] SRC_CRYSTAL  = 3'h1;
	localparam logic [2:0] SRC_EXT_MAIN = 3'h2;
	localparam logic [2:0] SRC_XT_SUB   = 3'h3;
	localparam logic [2:0] SRC_EXT_SUB  = 3'h4;
	// Oscillator bit positions in the run vectors
	localparam int OSC_INT_HS   = 0;
	localparam int OSC_CRYSTAL  = 1;
	localparam int OSC_XT_SUB   = 2;
	localparam int OSC_LOW      = 3;
	localparam int OSC_COUNT    = 4;
	localparam int SRC_COUNT    = 5;
	localparam logic [3:0] OSC_RESET = 4'h1;

	typedef enum logic [1:0] {
		HMCG_RUN  = 2'b01,
		HMCG_HALT = 2'b10
	} hmcg_state_type;
endpackage

// >>> tb/hmcg_halt_properties.sv
`timescale 1ns/1ps
module hmcg_chk (
	input wire logic       sys_clk,       // Clock
	input wire logic       rst,           // Reset
	input wire logic       halt_exec,     // Halt instruction
	input wire logic       wake,          // Release
	input wire logic       opt_low_stop,  // Option
	input wire logic [2:0] cpu_src,       // CPU source code
	input wire logic       ext_main_in,   // External main pin
	input wire logic       halted,        // State
	input wire logic       cpu_clk_en,    // CPU gate
	input wire logic       flash_en,      // Flash
	input wire logic       mem_wr_en,     // Memory
	input wire logic       wdt_clk_en,    // Watchdog
	input wire logic       periph_clk_en, // Peripherals
	input wire logic       ext_main_en,   // External main pass
	input wire logic [3:0] osc_run        // Oscillator enables
);
	import hmcg_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_halt_entry: assert property (!halted && halt_exec |=> halted) else $error("entry");
	a_no_trigger: assert property (!halted && !halt_exec |=> !halted) else $error("trig");
	a_cpu_gate: assert property (halted |-> !cpu_clk_en && !flash_en) else $error("gate");
	a_wake_exit: assert property (halted && wake |=> cpu_clk_en && flash_en) else $error("wake");
	a_halt_stay: assert property (halted && !wake |=> halted) else $error("stay");
	a_mem_hold: assert property (mem_wr_en != halted) else $error("mem");
	a_wdt_gate: assert property (wdt_clk_en == !(halted && opt_low_stop)) else $error("wdt");
	a_periph_on: assert property (periph_clk_en) else $error("periph");
	a_hs_kept: assert property (halted && cpu_src == SRC_INT_HS |-> osc_run[OSC_INT_HS])
		else $error("hs source stopped");
	a_xtal_kept: assert property (halted && cpu_src == SRC_CRYSTAL |-> osc_run[OSC_CRYSTAL])
		else $error("crystal source stopped");
	a_ext_follow: assert property (ext_main_in |=> ext_main_en) else $error("ext main");
endmodule
bind hmcg_halt hmcg_chk i_hmcg_chk (
	.sys_clk       (sys_clk),
	.rst           (rst),
	.halt_exec     (halt_exec),
	.wake          (wake),
	.opt_low_stop  (opt_low_stop),
	.cpu_src       (cpu_src),
	.ext_main_in   (ext_main_in),
	.halted        (halted),
	.cpu_clk_en    (cpu_clk_en),
	.flash_en      (flash_en),
	.mem_wr_en     (mem_wr_en),
	.wdt_clk_en    (wdt_clk_en),
	.periph_clk_en (periph_clk_en),
	.ext_main_en   (ext_main_en),
	.osc_run       (osc_run)
);

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import hmcg_pkg::*;
	logic        sys_clk = 0, rst = 1, halt_exec = 0, wake = 0, ext_main_in = 0, ext_sub_in = 0;
	logic        opt_low_stop = 0, hm = 0, halted, cpu_clk_en, flash_en, ext_main_en, ext_sub_en;
	logic        mem_wr_en, wdt_clk_en, periph_clk_en;
	logic [2:0]  cpu_src = 0;
	logic [3:0]  osc_req = 0, osc_run, snap = 0, s;
	logic [11:0] q[$];
	logic [31:0] x = 9;
	int          mismatches = 0, tests_run = 0;
	always #12.5 sys_clk = ~sys_clk;
	hmcg_halt i_hmcg_halt (
		.sys_clk       (sys_clk),
		.rst           (rst),
		.halt_exec     (halt_exec),
		.wake          (wake),
		.cpu_src       (cpu_src),
		.osc_req       (osc_req),
		.ext_main_in   (ext_main_in),
		.ext_sub_in    (ext_sub_in),
		.opt_low_stop  (opt_low_stop),
		.halted        (halted),
		.cpu_clk_en    (cpu_clk_en),
		.flash_en      (flash_en),
		.osc_run       (osc_run),
		.ext_main_en   (ext_main_en),
		.ext_sub_en    (ext_sub_en),
		.mem_wr_en     (mem_wr_en),
		.wdt_clk_en    (wdt_clk_en),
		.periph_clk_en (periph_clk_en)
	);
	function automatic logic [3:0] rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x[3:0];
	endfunction
	task automatic step(input logic he, wk, input logic [3:0] req);
		s = {1'b0, cpu_src == SRC_XT_SUB, cpu_src == SRC_CRYSTAL, cpu_src == SRC_INT_HS};
		halt_exec = he;
		wake = wk;
		osc_req = req;
		ext_main_in = x[5];
		ext_sub_in = x[6];
		if (hm && wk) hm = 0;
		else if (he) hm = 1;
		if (!hm) snap = req | s;
		@(posedge sys_clk);
		#1 q.push_back({hm, !hm, !hm, !hm, !(hm && opt_low_stop), 1'b1,
			ext_main_in | (cpu_src == SRC_EXT_MAIN), ext_sub_in | (cpu_src == SRC_EXT_SUB),
			snap | s});
	endtask
	task automatic chk(input logic [11:0] e);
		logic [11:0] got;
		got = {halted, cpu_clk_en, flash_en, mem_wr_en, wdt_clk_en, periph_clk_en,
			ext_main_en, ext_sub_en, osc_run};
		tests_run++;
		if (got !== e) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, e);
		end
	endtask
	always @(negedge sys_clk) if (q.size() > 0) chk(q.pop_front());
	task automatic test_done();
		$display("compares %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge sys_clk);
		#1 rst = 0;
		q.push_back(12'h7c1);
		for (int i = 0; i < SRC_COUNT; i++) begin
			cpu_src = i[2:0];
			opt_low_stop = i[0];
			// Wake while running, settle, enter, repeat halt, change requests, release
			for (int j = 0; j < 6; j++)
				step(j inside {2, 3}, j inside {0, 5}, (j inside {1, 2}) ? osc_req : rnd());
			$display("source %0d done", i);
		end
		// Let the last expectation be compared before the verdict
		@(negedge sys_clk);
		#1;
		test_done();
	end
	initial begin
		#20000;
		mismatches++;
		test_done();
	end
endmodule
